// ==== shared/fmt_map.svh ====
`ifndef FMT_MAP_SVH
`define FMT_MAP_SVH
// framing characters, parity bit already stripped
`define FMT_STX 7'h02
`define FMT_ETX 7'h03
`define FMT_ASTER 7'h2a
`define FMT_SPACE 7'h20
`define FMT_CR 7'h0d
`define FMT_LF 7'h0a
`define FMT_ZERO 7'h30
`define FMT_ONE 7'h31
`define FMT_NINE 7'h39
`define FMT_HEX_A 7'h41
`define FMT_HEX_F 7'h46
`define FMT_HEX_ADJ 4'h9
// store sizes
`define FMT_FUSE_MAX 13'h1000
`define FMT_FUSE_AW 12
`define FMT_PIN_MAX 5'h18
`define FMT_PIN_AW 5
`define FMT_VEC_MAX 16'h0040
`define FMT_VEC_AW 6
// value limits and digit counts
`define FMT_T_MAX 16'h0063
`define FMT_SIG_DIGITS 4'h8
`define FMT_XSUM_LAST 2'h3
`endif

// ==== shared/fmt_pkg.sv ====
package fmt_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DSPEC = 3'h1,
    ST_FID = 3'h2,
    ST_FBODY = 3'h3,
    ST_SWEEP = 3'h4,
    ST_XSUM = 3'h5
  } state_e;
  typedef enum logic [3:0] {
    FK_RSVD = 4'h0, FK_C = 4'h1, FK_D = 4'h2, FK_F = 4'h3, FK_G = 4'h4,
    FK_L = 4'h5, FK_M = 4'h6, FK_N = 4'h7, FK_P = 4'h8, FK_Q = 4'h9,
    FK_R = 4'ha, FK_S = 4'hb, FK_T = 4'hc, FK_V = 4'hd, FK_QP = 4'he, FK_QF = 4'hf
  } field_e;
  typedef enum logic [3:0] {
    SC_LOW = 4'h0, SC_HIGH = 4'h1, SC_SUPER = 4'h2, SC_CLK_LHL = 4'h3,
    SC_CLK_HLH = 4'h4, SC_UNTESTED = 4'h5, SC_EXP_LOW = 4'h6, SC_EXP_HIGH = 4'h7,
    SC_EXP_Z = 4'h8, SC_FLOAT = 4'h9, SC_PRELOAD = 4'ha, SC_HOLD = 4'hb,
    SC_UNKNOWN = 4'hf
  } sym_class_e;
endpackage

// ==== shared/fuse_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface fuse_if;
  logic clr;
  logic wr;
  logic [11:0] wr_addr;
  logic wr_bit;
  logic dflt;
  logic [11:0] rd_addr;
  logic rd_bit;
  modport owner (output clr, output wr, output wr_addr, output wr_bit, output dflt, output rd_addr,
                 input rd_bit);
  modport store (input clr, input wr, input wr_addr, input wr_bit, input dflt, input rd_addr,
                 output rd_bit);
endinterface
`default_nettype wire

// ==== rtl/fuse_store.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "fmt_map.svh"
module fuse_store (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // owner side
  fuse_if.store fif
);
  localparam int N = 4096;
  logic val [N];
  logic set_bits [N];

  // explicit bits cleared in one cycle per frame, so no fill sweep stalls the stream
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_fuse
      wire hit = fif.wr && (fif.wr_addr == 12'(i));
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          set_bits[i] <= 1'b0;
        end else if (fif.clr) begin
          set_bits[i] <= 1'b0;
        end else if (hit) begin
          set_bits[i] <= 1'b1;
        end
      end
      always_ff @(posedge clk_in) begin
        if (hit) begin
          val[i] <= fif.wr_bit;
        end
      end
    end
  endgenerate

  // unset fuses take the default state
  assign fif.rd_bit = set_bits[fif.rd_addr] ? val[fif.rd_addr] : fif.dflt;
endmodule // fuse_store
`default_nettype wire

// ==== rtl/fuse_map_transfer_receiver.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "fmt_map.svh"
// Function
// - 16-bit sum STX..ETX, parity ignored
// - frame: STX, spec, fields, ETX, 4 hex
// - design spec first, ends at asterisk
// - fields: identifier, body, asterisk terminator
// - decode the thirteen defined field identifiers
// - reserved identifiers cause no action
// - fuse stored as one bit
// - L field writes consecutive fuses from start
// - latest state for a fuse wins
// - F default applies to unset fuses
// - fuse checksum sums packed 8-bit words
// - unused bits of last word are zero
// - V: number, space, one symbol per pin
// - P field remaps vector symbols to pins
// - vector symbols stored without validation
// - symbols decode to drive/test classes
// - X: untested output, held input
// - T accepted only for 0 to 99
// - R needs exactly eight hex digits
// - S stored as per-pin drive pattern
// - G sets security fuse request
// - QP sets pin count per vector
// - received checksum 0000 always valid
// - QF sets fuse range of checksum
// - L number delimiter, spaces inside ignored
module fuse_map_transfer_receiver (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // character stream
  input wire logic [7:0] rx_data_in,
  input wire logic rx_valid_in,
  output logic rx_ready_out,
  // frame results
  output logic frame_done_out,
  output logic xsum_err_out,
  output logic fuse_err_out,
  output logic value_err_out,
  output logic [15:0] fuse_sum_out,
  // captured values
  output logic [4:0] pin_count_out,
  output logic [12:0] fuse_limit_out,
  output logic [6:0] test_cycles_out,
  output logic [31:0] signature_out,
  output logic [23:0] start_vec_out,
  output logic security_out,
  // fuse read port
  input wire logic [11:0] fuse_addr_in,
  output logic fuse_bit_out,
  // vector read port
  input wire logic [5:0] vec_num_in,
  input wire logic [4:0] vec_pin_in,
  output logic [6:0] vec_sym_out,
  output logic [3:0] vec_class_out
);
  fmt_pkg::state_e state;
  fmt_pkg::state_e next_state;
  fmt_pkg::field_e kind;
  fmt_pkg::field_e id_kind;
  fuse_if fif ();
  logic [15:0] xsum;
  logic [15:0] num;
  logic have_num;
  logic in_data;
  logic [31:0] hexacc;
  logic [3:0] dcnt;
  logic [12:0] idx;
  logic [5:0] vnum;
  logic vnum_ok;
  logic [15:0] c_val;
  logic c_seen;
  logic dflt;
  logic [15:0] rx_sum;
  logic [1:0] xcnt;
  logic [4:0] pin_map [24];
  logic [6:0] vec_mem [64][24];

  // character classes
  wire [6:0] ch = rx_data_in[6:0];
  wire acc = rx_valid_in && rx_ready_out;
  wire is_dig = (ch >= `FMT_ZERO) && (ch <= `FMT_NINE);
  wire is_hex = is_dig || ((ch >= `FMT_HEX_A) && (ch <= `FMT_HEX_F));
  wire [3:0] nib = is_dig ? ch[3:0] : ch[3:0] + `FMT_HEX_ADJ;
  wire is_del = (ch == `FMT_SPACE) || (ch == `FMT_CR) || (ch == `FMT_LF);
  wire is_bin = (ch == `FMT_ZERO) || (ch == `FMT_ONE);
  wire in_frame = (state == fmt_pkg::ST_DSPEC) || (state == fmt_pkg::ST_FID) || (state == fmt_pkg::ST_FBODY);
  wire frame_start = acc && (state == fmt_pkg::ST_IDLE) && (ch == `FMT_STX);
  wire frame_end = acc && (state == fmt_pkg::ST_FID) && (ch == `FMT_ETX);
  wire field_start = acc && (state == fmt_pkg::ST_FID) && !is_del && (ch != `FMT_ETX);
  wire body_acc = acc && (state == fmt_pkg::ST_FBODY) && (ch != `FMT_ASTER);
  wire field_end = acc && (state == fmt_pkg::ST_FBODY) && (ch == `FMT_ASTER);
  wire num_step = body_acc && is_dig && !in_data;
  wire [15:0] num_next = 16'((num << 3) + (num << 1) + {12'h000, ch[3:0]});
  wire data_go = body_acc && is_del && have_num && !in_data
                 && ((kind == fmt_pkg::FK_L) || (kind == fmt_pkg::FK_V));
  wire fuse_wr = body_acc && (kind == fmt_pkg::FK_L) && in_data && is_bin && (idx < `FMT_FUSE_MAX);
  wire vec_wr = body_acc && (kind == fmt_pkg::FK_V) && in_data && !is_del && vnum_ok
                && (idx < {8'h00, pin_count_out});
  wire s_wr = body_acc && (kind == fmt_pkg::FK_S) && is_bin && (idx < {8'h00, pin_count_out});
  wire p_num_end = ((body_acc && is_del) || field_end) && (kind == fmt_pkg::FK_P) && have_num;
  wire sweep_done = (state == fmt_pkg::ST_SWEEP) && (idx >= fuse_limit_out);
  wire xsum_last = acc && (state == fmt_pkg::ST_XSUM) && is_hex && (xcnt == `FMT_XSUM_LAST);
  wire [15:0] rx_full = {rx_sum[11:0], nib};

  // identifier decode, anything else is reserved
  assign id_kind = (ch == 7'h43) ? fmt_pkg::FK_C :
                   (ch == 7'h44) ? fmt_pkg::FK_D :
                   (ch == 7'h46) ? fmt_pkg::FK_F :
                   (ch == 7'h47) ? fmt_pkg::FK_G :
                   (ch == 7'h4c) ? fmt_pkg::FK_L :
                   (ch == 7'h4d) ? fmt_pkg::FK_M :
                   (ch == 7'h4e) ? fmt_pkg::FK_N :
                   (ch == 7'h50) ? fmt_pkg::FK_P :
                   (ch == 7'h51) ? fmt_pkg::FK_Q :
                   (ch == 7'h52) ? fmt_pkg::FK_R :
                   (ch == 7'h53) ? fmt_pkg::FK_S :
                   (ch == 7'h54) ? fmt_pkg::FK_T :
                   (ch == 7'h56) ? fmt_pkg::FK_V : fmt_pkg::FK_RSVD;

  always_comb begin
    next_state = state;
    case (state)
      fmt_pkg::ST_IDLE: if (frame_start) next_state = fmt_pkg::ST_DSPEC;
      fmt_pkg::ST_DSPEC: if (acc && (ch == `FMT_ASTER)) next_state = fmt_pkg::ST_FID;
      fmt_pkg::ST_FID: begin
        if (frame_end) next_state = fmt_pkg::ST_SWEEP;
        else if (field_start) next_state = fmt_pkg::ST_FBODY;
      end
      fmt_pkg::ST_FBODY: if (field_end) next_state = fmt_pkg::ST_FID;
      fmt_pkg::ST_SWEEP: if (sweep_done) next_state = fmt_pkg::ST_XSUM;
      fmt_pkg::ST_XSUM: if (xsum_last) next_state = fmt_pkg::ST_IDLE;
      default: next_state = fmt_pkg::ST_IDLE;
    endcase
  end

  // stream stalls while the fuse store is swept
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= fmt_pkg::ST_IDLE;
      rx_ready_out <= 1'b0;
    end else begin
      state <= next_state;
      rx_ready_out <= (next_state != fmt_pkg::ST_SWEEP);
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      xsum <= 16'h0000;
    end else if (frame_start) begin
      xsum <= {9'h000, ch};
    end else if (acc && in_frame) begin
      xsum <= xsum + {9'h000, ch};
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      kind <= fmt_pkg::FK_RSVD;
    end else if (field_start) begin
      kind <= id_kind;
    end else if (body_acc && (kind == fmt_pkg::FK_Q)) begin
      kind <= (ch == 7'h50) ? fmt_pkg::FK_QP : (ch == 7'h46) ? fmt_pkg::FK_QF : fmt_pkg::FK_N;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      num <= 16'h0000;
      have_num <= 1'b0;
      in_data <= 1'b0;
    end else if (field_start || p_num_end) begin
      num <= 16'h0000;
      have_num <= 1'b0;
      in_data <= 1'b0;
    end else if (num_step) begin
      num <= num_next;
      have_num <= 1'b1;
    end else if (data_go) begin
      in_data <= 1'b1;
    end
  end

  // idx walks fuses, pins or the checksum sweep
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      idx <= 13'h0000;
    end else if (field_start || frame_end) begin
      idx <= 13'h0000;
    end else if (data_go) begin
      idx <= (kind == fmt_pkg::FK_L) ? num[12:0] : 13'h0000;
    end else if (fuse_wr || vec_wr || s_wr || p_num_end || (state == fmt_pkg::ST_SWEEP && !sweep_done)) begin
      idx <= idx + 13'h0001;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      vnum <= 6'h00;
      vnum_ok <= 1'b0;
    end else if (data_go) begin
      vnum <= num[5:0];
      vnum_ok <= (num < `FMT_VEC_MAX);
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hexacc <= 32'h00000000;
      dcnt <= 4'h0;
    end else if (field_start) begin
      hexacc <= 32'h00000000;
      dcnt <= 4'h0;
    end else if (body_acc && is_hex && ((kind == fmt_pkg::FK_C) || (kind == fmt_pkg::FK_R))) begin
      hexacc <= {hexacc[27:0], nib};
      dcnt <= (dcnt == 4'hf) ? dcnt : dcnt + 4'h1;
    end
  end

  // per-frame captured values; a new frame restores defaults except c_val, which keeps its value
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dflt <= 1'b0;
      security_out <= 1'b0;
      c_seen <= 1'b0;
      c_val <= 16'h0000;
    end else if (frame_start) begin
      dflt <= 1'b0;
      security_out <= 1'b0;
      c_seen <= 1'b0;
    end else if (body_acc && is_bin && (kind == fmt_pkg::FK_F)) begin
      dflt <= ch[0];
    end else if (body_acc && is_bin && (kind == fmt_pkg::FK_G)) begin
      security_out <= ch[0];
    end else if (field_end && (kind == fmt_pkg::FK_C)) begin
      c_val <= hexacc[15:0];
      c_seen <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_count_out <= `FMT_PIN_MAX;
      fuse_limit_out <= `FMT_FUSE_MAX;
      test_cycles_out <= 7'h00;
      signature_out <= 32'h00000000;
      value_err_out <= 1'b0;
    end else if (frame_start) begin
      pin_count_out <= `FMT_PIN_MAX;
      fuse_limit_out <= `FMT_FUSE_MAX;
      value_err_out <= 1'b0;
    end else if (field_end) begin
      case (kind)
        fmt_pkg::FK_QP: begin
          if (num <= {11'h000, `FMT_PIN_MAX}) pin_count_out <= num[4:0];
          else value_err_out <= 1'b1;
        end
        fmt_pkg::FK_QF: begin
          if (num <= {3'h0, `FMT_FUSE_MAX}) fuse_limit_out <= num[12:0];
          else value_err_out <= 1'b1;
        end
        fmt_pkg::FK_T: begin
          if (have_num && (num <= `FMT_T_MAX)) test_cycles_out <= num[6:0];
          else value_err_out <= 1'b1;
        end
        fmt_pkg::FK_R: begin
          if (dcnt == `FMT_SIG_DIGITS) signature_out <= hexacc;
          else value_err_out <= 1'b1;
        end
        default: value_err_out <= value_err_out;
      endcase
    end
  end

  // pin order map: identity each frame, overwritten by a pin list
  genvar p;
  generate
    for (p = 0; p < 24; p++) begin : g_pin
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          pin_map[p] <= 5'(p);
          start_vec_out[p] <= 1'b0;
        end else begin
          if (frame_start) pin_map[p] <= 5'(p);
          else if (p_num_end && (idx == 13'(p))) pin_map[p] <= 5'(num - 16'h0001);
          if (s_wr && (idx == 13'(p))) start_vec_out[p] <= ch[0];
        end
      end
    end
  endgenerate

  // a repeated vector number overwrites the older symbols
  always_ff @(posedge clk_in) begin
    if (vec_wr) begin
      vec_mem[vnum][pin_map[idx[4:0]]] <= ch;
    end
  end

  // fuse store hookup
  assign fif.clr = frame_start;
  assign fif.wr = fuse_wr;
  assign fif.wr_addr = idx[11:0];
  assign fif.wr_bit = ch[0];
  assign fif.dflt = dflt;
  assign fif.rd_addr = (state == fmt_pkg::ST_SWEEP) ? idx[11:0] : fuse_addr_in;

  fuse_store u_store (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .fif(fif)
  );

  // weighting each fuse by 2^(n mod 8) equals summing packed words, with absent bits zero
  wire [15:0] fuse_weight = {15'h0000, fif.rd_bit} << idx[2:0];

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fuse_sum_out <= 16'h0000;
    end else if (frame_end) begin
      fuse_sum_out <= 16'h0000;
    end else if ((state == fmt_pkg::ST_SWEEP) && !sweep_done) begin
      fuse_sum_out <= fuse_sum_out + fuse_weight;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_sum <= 16'h0000;
      xcnt <= 2'h0;
    end else if (frame_end) begin
      rx_sum <= 16'h0000;
      xcnt <= 2'h0;
    end else if (acc && (state == fmt_pkg::ST_XSUM) && is_hex) begin
      rx_sum <= rx_full;
      xcnt <= xcnt + 2'h1;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      frame_done_out <= 1'b0;
      xsum_err_out <= 1'b0;
      fuse_err_out <= 1'b0;
    end else begin
      frame_done_out <= xsum_last;
      if (frame_start) begin
        xsum_err_out <= 1'b0;
        fuse_err_out <= 1'b0;
      end else if (xsum_last) begin
        xsum_err_out <= (rx_full != 16'h0000) && (rx_full != xsum);
        fuse_err_out <= c_seen && (c_val != fuse_sum_out);
      end
    end
  end

  // symbol class decode for the read port; X holds inputs, skips outputs
  wire [6:0] rd_sym = (vec_pin_in < `FMT_PIN_MAX) ? vec_mem[vec_num_in][vec_pin_in] : 7'h00;
  wire [3:0] rd_class = (rd_sym == 7'h30) ? fmt_pkg::SC_LOW :
                        (rd_sym == 7'h31) ? fmt_pkg::SC_HIGH :
                        (rd_sym >= 7'h32 && rd_sym <= `FMT_NINE) ? fmt_pkg::SC_SUPER :
                        (rd_sym == 7'h43) ? fmt_pkg::SC_CLK_LHL :
                        (rd_sym == 7'h4b) ? fmt_pkg::SC_CLK_HLH :
                        (rd_sym == 7'h4e) ? fmt_pkg::SC_UNTESTED :
                        (rd_sym == 7'h4c) ? fmt_pkg::SC_EXP_LOW :
                        (rd_sym == 7'h48) ? fmt_pkg::SC_EXP_HIGH :
                        (rd_sym == 7'h5a) ? fmt_pkg::SC_EXP_Z :
                        (rd_sym == 7'h46) ? fmt_pkg::SC_FLOAT :
                        (rd_sym == 7'h50) ? fmt_pkg::SC_PRELOAD :
                        (rd_sym == 7'h58) ? fmt_pkg::SC_HOLD : fmt_pkg::SC_UNKNOWN;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      vec_sym_out <= 7'h00;
      vec_class_out <= 4'h0;
      fuse_bit_out <= 1'b0;
    end else begin
      vec_sym_out <= rd_sym;
      vec_class_out <= rd_class;
      fuse_bit_out <= fif.rd_bit;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  run_sum_a: assert property (acc && in_frame |=> xsum == $past(xsum) + {9'h000, $past(ch)})
    else $error("transmission sum missed a character");
  done_order_a: assert property (frame_done_out |-> $past(state) == fmt_pkg::ST_XSUM)
    else $error("frame done outside checksum digits");
  zero_sum_a: assert property (xsum_last && (rx_full == 16'h0000) |=> frame_done_out && !xsum_err_out)
    else $error("zero checksum not accepted");
  sum_mismatch_a: assert property (xsum_last && (rx_full != 16'h0000) && (rx_full != xsum) |=> xsum_err_out)
    else $error("checksum mismatch not flagged");
  tcycles_range_a: assert property (test_cycles_out <= 7'h63)
    else $error("test cycles above limit");
  sig_len_a: assert property (field_end && (kind == fmt_pkg::FK_R) && (dcnt != 4'h8) |=> $stable(signature_out))
    else $error("short signature accepted");
  sec_set_a: assert property (body_acc && (kind == fmt_pkg::FK_G) && is_bin |=> security_out == $past(ch[0]))
    else $error("security request not taken");
  rsvd_quiet_a: assert property ((state == fmt_pkg::ST_FBODY) && (kind == fmt_pkg::FK_RSVD)
    |=> $stable(signature_out) && $stable(pin_count_out) && $stable(test_cycles_out))
    else $error("reserved field changed a value");
  fuse_walk_a: assert property (fuse_wr |=> idx == $past(idx) + 13'h0001)
    else $error("fuse address did not advance");
  sweep_stall_a: assert property ((state == fmt_pkg::ST_SWEEP) |-> !rx_ready_out)
    else $error("stream accepted during sweep");
endmodule // fuse_map_transfer_receiver
`default_nettype wire

// ==== test/fmt_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module fmt_host (
  // clock
  input wire logic clk_in,
  // character stream
  input wire logic ready_in,
  output logic [7:0] data_out,
  output logic valid_out
);
  logic hung = 1'b0;
  logic [15:0] sum;
  initial begin
    data_out = 8'h00;
    valid_out = 1'b0;
  end
  // hold the character until taken; the fuse sweep may stall ready for thousands of cycles
  task automatic put(input logic [7:0] c);
    int n;
    data_out <= c;
    valid_out <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (ready_in !== 1'b1 && n < 6000);
    if (n >= 6000) hung = 1'b1;
  endtask
  function automatic logic [7:0] hexc(input logic [3:0] v);
    return (v < 4'ha) ? 8'h30 + 8'(v) : 8'h37 + 8'(v);
  endfunction
  // mode 0 true sum, 1 all zero, 2 corrupted; par sets bit 7 on body characters
  task automatic frame(input string body, input logic [1:0] mode, input logic par);
    logic [7:0] c;
    logic [15:0] x;
    @(posedge clk_in);
    sum = 16'h0000;
    for (int i = -1; i <= body.len(); i++) begin
      c = (i < 0) ? 8'h02 : (i == body.len()) ? 8'h03 : body[i];
      sum = sum + {9'h000, c[6:0]};
      put({par & (i >= 0) & (i < body.len()), c[6:0]});
    end
    x = (mode == 2'h1) ? 16'h0000 : (mode == 2'h2) ? sum ^ 16'h0001 : sum;
    for (int k = 3; k >= 0; k--) put(hexc(x[4*k +: 4]));
    valid_out <= 1'b0;
    // a released line must not keep showing the last character
    data_out <= ~data_out;
  endtask
endmodule // fmt_host
`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] rx_data;
  logic rx_valid, rx_ready, frame_done, xsum_err, fuse_err, value_err, security, fuse_bit;
  logic [15:0] fuse_sum;
  logic [4:0] pin_count;
  logic [12:0] fuse_limit;
  logic [6:0] test_cycles, vec_sym;
  logic [31:0] signature;
  logic [23:0] start_vec;
  logic [3:0] vec_class;
  logic [11:0] fuse_addr = 12'h000;
  logic [5:0] vec_num = 6'h00;
  logic [4:0] vec_pin = 5'h00;
  int n_mismatch = 0;
  int compares = 0;
  always #10 clk_in = ~clk_in;
  fmt_host host (.clk_in(clk_in), .ready_in(rx_ready), .data_out(rx_data), .valid_out(rx_valid));
  fuse_map_transfer_receiver dut (.clk_in(clk_in), .nrst_in(nrst_in), .rx_data_in(rx_data),
    .rx_valid_in(rx_valid), .rx_ready_out(rx_ready), .frame_done_out(frame_done),
    .xsum_err_out(xsum_err), .fuse_err_out(fuse_err), .value_err_out(value_err),
    .fuse_sum_out(fuse_sum), .pin_count_out(pin_count), .fuse_limit_out(fuse_limit),
    .test_cycles_out(test_cycles), .signature_out(signature), .start_vec_out(start_vec),
    .security_out(security), .fuse_addr_in(fuse_addr), .fuse_bit_out(fuse_bit),
    .vec_num_in(vec_num), .vec_pin_in(vec_pin), .vec_sym_out(vec_sym), .vec_class_out(vec_class));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge host.hung) begin
    check("stream_stall", host.hung, 1'b0);
    print_verdict();
  end
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (frame_done !== 1'b1 && n < 10);
    check("frame_done", frame_done, 1'b1);
    if (frame_done !== 1'b1) print_verdict();
  endtask
  task automatic rd_fuse(input logic [11:0] a, input logic exp);
    @(posedge clk_in);
    fuse_addr <= a;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    check("fuse_bit", fuse_bit, exp);
  endtask
  task automatic rd_vec(input logic [5:0] n, input logic [4:0] p, input logic [6:0] sym, input logic [3:0] cls);
    @(posedge clk_in);
    vec_num <= n;
    vec_pin <= p;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    check("vec_sym", vec_sym, sym);
    check("vec_class", vec_class, cls);
  endtask
  task automatic s_example();
    host.frame("TEST*\015\nQF0384*\015\nF0*  \015\nL10 101*\015\n", 2'h0, 1'b0);
    wait_done();
    check("xsum_err", xsum_err, 1'b0);
    check("fuse_limit", fuse_limit, 13'h0180);
    check("fuse_sum", fuse_sum, 16'h0014);
    rd_fuse(12'h009, 1'b0);
    rd_fuse(12'h00a, 1'b1);
    rd_fuse(12'h00b, 1'b0);
    rd_fuse(12'h00c, 1'b1);
  endtask
  task automatic s_fuse();
    host.frame("X*X9*QF12*F1*L0003\0150 0*L4 1*C0106*", 2'h0, 1'b1);
    wait_done();
    check("xsum_err", xsum_err, 1'b0);
    check("fuse_err", fuse_err, 1'b0);
    check("fuse_limit", fuse_limit, 13'h000c);
    check("fuse_sum", fuse_sum, 16'h0106);
    rd_fuse(12'h003, 1'b0);
    rd_fuse(12'h004, 1'b1);
    rd_fuse(12'h00b, 1'b1);
    host.frame("X*QF12*F1*L3 0*C0107*", 2'h2, 1'b0);
    wait_done();
    check("xsum_err", xsum_err, 1'b1);
    check("fuse_err", fuse_err, 1'b1);
    host.frame("X*QF12*F1*L3 0*C0107*", 2'h1, 1'b0);
    wait_done();
    check("xsum_err", xsum_err, 1'b0);
    check("fuse_err", fuse_err, 1'b1);
  endtask
  task automatic s_symbols();
    string sy;
    logic [3:0] cl [14];
    sy = "012CKNLHZFPX9W";
    cl = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'h2, 4'hf};
    host.frame("SPEC*QP14*V5 012CKNLHZFPX9W*", 2'h0, 1'b0);
    wait_done();
    check("pin_count", pin_count, 5'h0e);
    for (int p = 0; p < 14; p++) rd_vec(6'h05, 5'(p), 7'(sy[p]), cl[p]);
  endtask
  task automatic s_pins();
    host.frame("SPEC*QP4*P 4 3 2 1*V2 01HX*S1011*R5BCD34A7*T99*G1*", 2'h0, 1'b0);
    wait_done();
    check("pin_count", pin_count, 5'h04);
    rd_vec(6'h02, 5'h03, 7'h30, 4'h0);
    rd_vec(6'h02, 5'h02, 7'h31, 4'h1);
    rd_vec(6'h02, 5'h01, 7'h48, 4'h7);
    rd_vec(6'h02, 5'h00, 7'h58, 4'hb);
    check("start_vec", start_vec, 24'h00000d);
    check("signature", signature, 32'h5bcd34a7);
    check("test_cycles", test_cycles, 7'h63);
    check("security", security, 1'b1);
    check("value_err", value_err, 1'b0);
    // out of range count and a short signature in one frame
    host.frame("SPEC*QP4*T100*R12345*G0*", 2'h0, 1'b0);
    wait_done();
    check("value_err", value_err, 1'b1);
    check("security", security, 1'b0);
  endtask
  initial begin
    repeat (16) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    check("rx_ready", rx_ready, 1'b1);
    check("pin_count", pin_count, 5'h18);
    check("fuse_limit", fuse_limit, 13'h1000);
    s_example();
    s_fuse();
    s_symbols();
    s_pins();
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
